// *** common/i2c_flag_pkg.sv ***
// Shared constants for the FIFO level and FIFO error flag block.
// Assumes a register port with byte offsets and 32-bit read data.
package i2c_flag_pkg;

  // Register byte offsets on the register port
  localparam logic [7:0] OFS_RX_THR = 8'h38;
  localparam logic [7:0] OFS_TX_THR = 8'h3C;
  localparam logic [7:0] OFS_CLR_ALL = 8'h40;
  localparam logic [7:0] OFS_CLR_UNDER = 8'h44;

  // Threshold field layout and reset value
  localparam int THR_W = 8;
  localparam logic [7:0] THR_RESET = 8'h00;

  // Raw flag vector layout
  localparam int RAW_W = 5;
  localparam int RAW_RX_UNDER = 0;
  localparam int RAW_RX_OVER = 1;
  localparam int RAW_RX_FULL = 2;
  localparam int RAW_TX_OVER = 3;
  localparam int RAW_TX_EMPTY = 4;
  localparam logic [4:0] RAW_RESET = 5'h00;

  // Positions of the outside control bits that arrive as plain inputs
  localparam int ENABLE_BIT = 0;
  localparam int CTRL_HOLD_BIT = 9;
  localparam int ABORT_KEEP_BIT = 9;

  // Default FIFO depths
  localparam int RX_DEPTH_DEFAULT = 16;
  localparam int TX_DEPTH_DEFAULT = 16;

  // Data byte width on the link
  localparam int BYTE_W = 8;

endpackage

// *** common/link_xfer_if.sv ***
// Core-side bundle of everything that crosses from the link clock domain.
// Every signal here except rx_byte, a link_clk register held stable while valid, is in the core_clk domain.
`timescale 1ns/100ps
interface link_xfer_if;
  import i2c_flag_pkg::*;
  logic rx_valid; // A received byte is waiting, held stable
  logic [BYTE_W-1:0] rx_byte; // The waiting byte
  logic rx_take; // Core accepts the waiting byte, one cycle
  logic tx_pop; // Engine removed one transmit entry, one cycle
  logic link_idle; // Engine state machines idle, synchronised level

  modport rx_end (output rx_valid, output rx_byte, input rx_take);
  modport ev_end (output tx_pop, output link_idle);
  modport core (input rx_valid, input rx_byte, output rx_take, input tx_pop, input link_idle);
endinterface

// *** hdl/link_rx_handshake.sv ***
// Carries received bytes from the link clock into core_clk by a toggle handshake.
// Assumes the engine offers a byte only while busy is low.
`timescale 1ns/100ps
module link_rx_handshake
  import i2c_flag_pkg::*;
(
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [BYTE_W-1:0] byte_in,
  input wire logic byte_strobe,
  output logic busy,
  link_xfer_if.rx_end xfer
);
  logic [BYTE_W-1:0] hold_byte; // Stable while a request is open
  logic req_t; // Request toggle, link domain
  logic ack_s1; // Ack toggle synchroniser, first stage
  logic ack_s2; // Ack toggle synchroniser, second stage
  logic req_s1; // Request toggle synchroniser, first stage
  logic req_s2; // Request toggle synchroniser, second stage
  logic req_seen; // Last request accepted by the core
  logic ack_t; // Ack toggle, core domain

  wire start = byte_strobe && !busy;

  // Link side: capture the byte and open a request
  always_ff @(posedge link_clk) begin
    if (!link_nrst) begin
      req_t <= 1'b0;
      busy <= 1'b0;
      hold_byte <= '0;
    end else begin
      if (start) begin
        req_t <= ~req_t;
        hold_byte <= byte_in;
      end
      // Busy until the core's ack toggle comes back
      busy <= start ? 1'b1 : (req_t != ack_s2);
    end
  end

  // Link side: bring the ack toggle over
  always_ff @(posedge link_clk) begin
    if (!link_nrst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
    end
  end

  // Core side: bring the request over, answer when taken
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_seen <= 1'b0;
      ack_t <= 1'b0;
    end else begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      if (xfer.rx_take) begin
        req_seen <= req_s2;
        ack_t <= ~ack_t;
      end
    end
  end

  assign xfer.rx_valid = (req_s2 != req_seen);
  assign xfer.rx_byte = hold_byte;
endmodule

// *** hdl/link_event_sync.sv ***
// Brings transmit pops and the engine idle level from the link clock into core_clk.
// Assumes pops come no faster than one per link clock cycle.
`timescale 1ns/100ps
module link_event_sync (
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tx_pop_in,
  input wire logic engine_idle,
  link_xfer_if.ev_end xfer
);
  logic pop_t; // Pop toggle, link domain
  logic pop_s1; // Toggle synchroniser, first stage
  logic pop_s2; // Toggle synchroniser, second stage
  logic pop_s3; // Previous toggle for edge detect
  logic idle_s1; // Idle synchroniser, first stage
  logic idle_s2; // Idle synchroniser, second stage

  // Link side: each pop flips the toggle
  always_ff @(posedge link_clk) begin
    if (!link_nrst) begin
      pop_t <= 1'b0;
    end else if (tx_pop_in) begin
      pop_t <= ~pop_t;
    end
  end

  // Core side: two stages, then edge detect on the second
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pop_s1 <= 1'b0;
      pop_s2 <= 1'b0;
      pop_s3 <= 1'b0;
      idle_s1 <= 1'b1;
      idle_s2 <= 1'b1;
    end else begin
      pop_s1 <= pop_t;
      pop_s2 <= pop_s1;
      pop_s3 <= pop_s2;
      idle_s1 <= engine_idle;
      idle_s2 <= idle_s1;
    end
  end

  assign xfer.tx_pop = pop_s2 ^ pop_s3;
  assign xfer.link_idle = idle_s2;
endmodule

// *** hdl/i2c_fifo_flags.sv ***
// FIFO level and FIFO error flags with threshold and read-to-clear registers.
// Assumes same-clock inputs for enable, hold control and the data port strobes;
// the bus engine runs on link_clk with its own synchronous reset.
`timescale 1ns/100ps

// Operation
// - Full transmit FIFO plus write sets overflow
// - Error flags hold until internal enable drops
// - Receive level flag follows threshold comparison
// - Disable flushes receive FIFO, clears level flag
// - Byte into full FIFO dropped, overflow set
// - Hold control stalls link, no overflow
// - Read of empty receive FIFO sets underflow
// - Receive threshold N triggers at N+1
// - Threshold writes above depth clamp to depth
// - Transmit flag set at or below threshold
// - Combined clear read clears software flags
// - Combined clear leaves hardware flags alone
// - Abort cause clear honours bit nine exception
// - Underflow clear read clears underflow flag
// - Transmit flag clears above threshold
module i2c_fifo_flags
  import i2c_flag_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEFAULT,
  parameter int TX_DEPTH = TX_DEPTH_DEFAULT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic link_nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic controller_enable,
  input wire logic receive_full_hold_control,
  input wire logic data_command_write,
  input wire logic data_command_read,
  output logic [BYTE_W-1:0] rx_data,
  input wire logic [BYTE_W-1:0] link_rx_byte,
  input wire logic link_rx_strobe,
  output logic link_rx_busy,
  input wire logic link_tx_pop,
  input wire logic link_engine_idle,
  input wire logic abort_cause_bit9,
  output logic abort_cause_clear,
  output logic internal_enable_state,
  output logic [RAW_W-1:0] raw_interrupt_flags
);
  // Pointer and level widths
  localparam int RX_AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int RX_LW = $clog2(RX_DEPTH + 1);
  localparam int TX_LW = $clog2(TX_DEPTH + 1);
  // Depths widened to one bit over the threshold field
  localparam logic [THR_W:0] RX_DEPTH_X = (THR_W + 1)'(RX_DEPTH);
  localparam logic [THR_W:0] TX_DEPTH_X = (THR_W + 1)'(TX_DEPTH);
  // Clamp values; only used when the depth fits in the field
  localparam logic [THR_W-1:0] RX_THR_MAX = RX_DEPTH_X[THR_W-1:0];
  localparam logic [THR_W-1:0] TX_THR_MAX = TX_DEPTH_X[THR_W-1:0];
  localparam logic [RX_LW-1:0] RX_FULL_LVL = RX_LW'(RX_DEPTH);
  localparam logic [TX_LW-1:0] TX_FULL_LVL = TX_LW'(TX_DEPTH);
  localparam logic [RX_AW-1:0] RX_LAST_PTR = RX_AW'(RX_DEPTH - 1);

  // Crossing bundle from the link domain
  link_xfer_if xfer();

  // Programmed thresholds
  logic [THR_W-1:0] rx_thr; // Receive threshold field
  logic [THR_W-1:0] tx_thr; // Transmit threshold field

  // Receive FIFO storage and state, and the transmit level
  logic [BYTE_W-1:0] rx_mem [RX_DEPTH]; // Received bytes
  logic [RX_AW-1:0] rx_wr_ptr; // Next slot to fill
  logic [RX_AW-1:0] rx_rd_ptr; // Next slot to read
  logic [RX_LW-1:0] rx_level; // Entries held
  logic [TX_LW-1:0] tx_level; // Transmit entries held

  // Byte crossing from the engine
  link_rx_handshake u_rx_cross (
    .link_clk(link_clk),
    .link_nrst(link_nrst),
    .core_clk(core_clk),
    .nrst(nrst),
    .byte_in(link_rx_byte),
    .byte_strobe(link_rx_strobe),
    .busy(link_rx_busy),
    .xfer(xfer.rx_end)
  );

  // Pop event and idle level crossing
  link_event_sync u_ev_cross (
    .link_clk(link_clk),
    .link_nrst(link_nrst),
    .core_clk(core_clk),
    .nrst(nrst),
    .tx_pop_in(link_tx_pop),
    .engine_idle(link_engine_idle),
    .xfer(xfer.ev_end)
  );

  // Register decode
  wire sel_rx_thr = (reg_addr == OFS_RX_THR);
  wire sel_tx_thr = (reg_addr == OFS_TX_THR);
  wire sel_clr_all = (reg_addr == OFS_CLR_ALL);
  wire sel_clr_under = (reg_addr == OFS_CLR_UNDER);
  wire wr_rx_thr = reg_write && sel_rx_thr;
  wire wr_tx_thr = reg_write && sel_tx_thr;
  wire rd_clr_all = reg_read && sel_clr_all;
  wire rd_clr_under = reg_read && sel_clr_under;

  wire [THR_W:0] wr_thr_x = {1'b0, reg_wdata[THR_W-1:0]};
  wire [THR_W-1:0] rx_thr_wr = (wr_thr_x > RX_DEPTH_X) ? RX_THR_MAX : reg_wdata[THR_W-1:0];
  wire [THR_W-1:0] tx_thr_wr = (wr_thr_x > TX_DEPTH_X) ? TX_THR_MAX : reg_wdata[THR_W-1:0];

  wire rx_flush = !controller_enable;
  wire tx_flush = !controller_enable;

  // Internal enable drops only once the engine is idle
  wire next_en = controller_enable || (internal_enable_state && !xfer.link_idle);

  // Receive side status
  wire rx_is_full = (rx_level == RX_FULL_LVL);
  wire rx_is_empty = (rx_level == '0);
  // With hold control, a byte waits while full
  wire rx_stall = rx_is_full && receive_full_hold_control && !rx_flush;
  assign xfer.rx_take = xfer.rx_valid && !rx_stall;
  wire rx_push = xfer.rx_take && !rx_flush && !rx_is_full;
  // Taken into a full FIFO: byte is lost
  wire rx_over_evt = xfer.rx_take && !rx_flush && rx_is_full;
  wire rx_pop = data_command_read && !rx_is_empty && !rx_flush;
  wire rx_under_evt = data_command_read && rx_is_empty;
  wire [RX_LW-1:0] next_rx_level = rx_flush ? '0 : (rx_level + RX_LW'(rx_push) - RX_LW'(rx_pop));
  wire [RX_AW-1:0] next_wr_ptr = (rx_wr_ptr == RX_LAST_PTR) ? '0 : (rx_wr_ptr + 1'b1);
  wire [RX_AW-1:0] next_rd_ptr = (rx_rd_ptr == RX_LAST_PTR) ? '0 : (rx_rd_ptr + 1'b1);

  // Transmit side status
  wire tx_is_full = (tx_level == TX_FULL_LVL);
  wire tx_push = data_command_write && !tx_flush && !tx_is_full;
  // Command written into a full FIFO
  wire tx_over_evt = data_command_write && !tx_flush && tx_is_full;
  wire tx_pop = xfer.tx_pop && (tx_level != '0) && !tx_flush;
  wire [TX_LW-1:0] next_tx_level = tx_flush ? '0 : (tx_level + TX_LW'(tx_push) - TX_LW'(tx_pop));

  // Software-cleared flags: event beats clear; all drop with internal enable
  // Hold until internal enable drops
  wire next_tx_over = next_en && (tx_over_evt || (raw_interrupt_flags[RAW_TX_OVER] && !rd_clr_all));
  wire next_rx_over = next_en && (rx_over_evt || (raw_interrupt_flags[RAW_RX_OVER] && !rd_clr_all));
  wire keep_under = raw_interrupt_flags[RAW_RX_UNDER] && !rd_clr_all && !rd_clr_under;
  wire next_rx_under = next_en && (rx_under_evt || keep_under);

  // Hardware-cleared flags, untouched by clear reads
  // Level flags ignore clear reads
  // Level above N means N+1 or more
  wire next_rx_full = !rx_flush && ({1'b0, THR_W'(next_rx_level)} > {1'b0, rx_thr});
  wire next_tx_empty = next_en && ({1'b0, THR_W'(next_tx_level)} <= {1'b0, tx_thr});

  // Assemble the next raw flag vector
  wire [RAW_W-1:0] next_raw = {next_tx_empty, next_tx_over, next_rx_full, next_rx_over, next_rx_under};

  // Register read mux; reserved bits zero
  wire sw_flag_any = raw_interrupt_flags[RAW_TX_OVER] || raw_interrupt_flags[RAW_RX_OVER] ||
                     raw_interrupt_flags[RAW_RX_UNDER];
  wire [31:0] rd_value = sel_rx_thr ? {24'h000000, rx_thr} :
                         sel_tx_thr ? {24'h000000, tx_thr} :
                         sel_clr_all ? {31'h00000000, sw_flag_any} :
                         sel_clr_under ? {31'h00000000, raw_interrupt_flags[RAW_RX_UNDER]} :
                         32'h00000000;

  // Abort cause cleared unless exception bit set
  wire next_abort_clear = rd_clr_all && !abort_cause_bit9;

  // Threshold registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_thr <= THR_RESET;
      tx_thr <= THR_RESET;
    end else begin
      if (wr_rx_thr) begin
        rx_thr <= rx_thr_wr;
      end
      if (wr_tx_thr) begin
        tx_thr <= tx_thr_wr;
      end
    end
  end

  // Receive FIFO pointers and level
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_level <= '0;
    end else if (rx_flush) begin
      // Held in reset while disabled
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_level <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr <= next_wr_ptr;
      end
      if (rx_pop) begin
        rx_rd_ptr <= next_rd_ptr;
      end
      rx_level <= next_rx_level;
    end
  end

  // Receive FIFO storage, data only, no reset
  always_ff @(posedge core_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ptr] <= xfer.rx_byte;
    end
  end

  // Read data for the data command port
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_data <= '0;
    end else if (rx_pop) begin
      rx_data <= rx_mem[rx_rd_ptr];
    end
  end

  // Transmit level counter
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_level <= '0;
    end else begin
      tx_level <= next_tx_level;
    end
  end

  // Flags reset to zero, no write path
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      raw_interrupt_flags <= RAW_RESET;
      internal_enable_state <= 1'b0;
    end else begin
      raw_interrupt_flags <= next_raw;
      internal_enable_state <= next_en;
    end
  end

  // Register read data and abort clear pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
      abort_cause_clear <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? rd_value : 32'h00000000;
      abort_cause_clear <= next_abort_clear;
    end
  end
endmodule

// *** dv/i2c_fifo_flags_asserts.sv ***
// Port checker for the FIFO level and error flag block.
// Assumes every watched port belongs to the core_clk domain.
`timescale 1ns/100ps
module i2c_fifo_flags_asserts
  import i2c_flag_pkg::*;
#(
  parameter int RX_DEPTH = RX_DEPTH_DEFAULT,
  parameter int TX_DEPTH = TX_DEPTH_DEFAULT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic controller_enable,
  input wire logic receive_full_hold_control,
  input wire logic data_command_write,
  input wire logic data_command_read,
  input wire logic abort_cause_bit9,
  input wire logic abort_cause_clear,
  input wire logic internal_enable_state,
  input wire logic [RAW_W-1:0] raw_interrupt_flags
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Decoded clear reads and a short alias of the flags
  wire logic clr_all = reg_read && reg_addr == OFS_CLR_ALL;
  wire logic clr_under = reg_read && reg_addr == OFS_CLR_UNDER;
  wire logic [4:0] raw = raw_interrupt_flags;

  a_under_clear: assert property (clr_under && !data_command_read |=> !raw[0])
    else $error("underflow flag survived its clear read");
  a_under_value: assert property (clr_under |=> reg_rdata == {31'h0, $past(raw[0])})
    else $error("underflow clear read returned a wrong value");
  a_all_clear: assert property (clr_all && !data_command_read && !data_command_write
    |=> raw[3] == 1'b0 && raw[0] == 1'b0)
    else $error("combined clear left a software flag set");
  a_abort_pulse: assert property (clr_all && !abort_cause_bit9 |=> abort_cause_clear)
    else $error("combined clear gave no abort cause clear");
  a_abort_keep: assert property (clr_all && abort_cause_bit9 |=> !abort_cause_clear)
    else $error("abort cause cleared despite keep bit");
  a_level_drop: assert property (!controller_enable |=> !raw[2])
    else $error("rx level flag stayed set while disabled");
  a_error_drop: assert property ($fell(internal_enable_state) |-> (raw & 5'h0B) == 5'h00)
    else $error("error flags survived the enable fall");
  a_under_hold: assert property (raw[0] && controller_enable && !clr_all && !clr_under |=> raw[0])
    else $error("underflow flag dropped without a clear");
  a_hold_no_over: assert property (receive_full_hold_control[*4] ##0 !raw[1] |=> !raw[1])
    else $error("rx overflow raised while hold control set");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero without a read");
  a_rsvd_zero: assert property (reg_read |=> reg_rdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  a_enable_follow: assert property (controller_enable |=> internal_enable_state)
    else $error("internal enable did not follow enable");
endmodule

bind i2c_fifo_flags i2c_fifo_flags_asserts #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) chk_inst (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .controller_enable(controller_enable),
  .receive_full_hold_control(receive_full_hold_control), .data_command_write(data_command_write),
  .data_command_read(data_command_read), .abort_cause_bit9(abort_cause_bit9),
  .abort_cause_clear(abort_cause_clear), .internal_enable_state(internal_enable_state),
  .raw_interrupt_flags(raw_interrupt_flags)
);

// *** dv/link_engine_model.sv ***
// Behavioural bus engine on the link side of the flag block.
// Assumes the bench strobes only while the block's busy is low.
`timescale 1ns/100ps
module link_engine_model
  import i2c_flag_pkg::*;
(
  input wire logic link_clk,
  output logic [BYTE_W-1:0] rx_byte,
  output logic rx_strobe,
  output logic tx_pop,
  output logic engine_idle
);
  // Engine starts busy so disabling holds the error flags
  initial begin
    rx_byte = 8'hA5;
    rx_strobe = 1'b0;
    tx_pop = 1'b0;
    engine_idle = 1'b0;
  end
  // One received byte; the data line toggles once the strobe ends
  task automatic send(input logic [BYTE_W-1:0] b);
    @(posedge link_clk);
    #2;
    rx_byte = b;
    rx_strobe = 1'b1;
    @(posedge link_clk);
    #2;
    rx_strobe = 1'b0;
    rx_byte = ~b;
  endtask
  // Engine takes one transmit entry
  task automatic pop;
    @(posedge link_clk);
    #2;
    tx_pop = 1'b1;
    @(posedge link_clk);
    #2;
    tx_pop = 1'b0;
  endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the FIFO flag block.
// Assumes the bound checker and the link engine model beside it.
`timescale 1ns/100ps
module tb_top
  import i2c_flag_pkg::*;
;
  localparam int DEPTH = 16;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic controller_enable = 1'b0;
  logic receive_full_hold_control = 1'b0;
  logic data_command_write = 1'b0;
  logic data_command_read = 1'b0;
  logic abort_cause_bit9 = 1'b0;
  logic [31:0] reg_rdata, rd_val;
  logic [7:0] rx_data, link_rx_byte;
  logic link_rx_strobe, link_rx_busy, link_tx_pop, link_engine_idle, abort_cause_clear, internal_enable_state;
  logic [4:0] raw;
  logic [7:0] ofs [2] = '{OFS_RX_THR, OFS_TX_THR};
  int mismatches = 0;
  int cmp_count = 0;

  // Core clock 25 ns, link clock 80 ns with an unrelated offset
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end

  i2c_fifo_flags #(.RX_DEPTH(DEPTH), .TX_DEPTH(DEPTH)) i2c_fifo_flags_inst (
    .core_clk(core_clk), .nrst(nrst), .link_clk(link_clk), .link_nrst(nrst),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .controller_enable(controller_enable),
    .receive_full_hold_control(receive_full_hold_control), .data_command_write(data_command_write),
    .data_command_read(data_command_read), .rx_data(rx_data), .link_rx_byte(link_rx_byte),
    .link_rx_strobe(link_rx_strobe), .link_rx_busy(link_rx_busy), .link_tx_pop(link_tx_pop),
    .link_engine_idle(link_engine_idle), .abort_cause_bit9(abort_cause_bit9),
    .abort_cause_clear(abort_cause_clear), .internal_enable_state(internal_enable_state),
    .raw_interrupt_flags(raw)
  );
  link_engine_model link_engine_model_inst (
    .link_clk(link_clk), .rx_byte(link_rx_byte), .rx_strobe(link_rx_strobe),
    .tx_pop(link_tx_pop), .engine_idle(link_engine_idle)
  );

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Register access: one strobe cycle, read data in the cycle after
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_write = wr;
    reg_read = !wr;
    @(posedge core_clk);
    #2;
    reg_write = 1'b0;
    reg_read = 1'b0;
    rd_val = reg_rdata;
  endtask
  // Data command port pulse, write or read
  task automatic dcmd(input logic wr);
    @(posedge core_clk);
    #2;
    data_command_write = wr;
    data_command_read = !wr;
    @(posedge core_clk);
    #2;
    data_command_write = 1'b0;
    data_command_read = 1'b0;
  endtask
  // Bounded wait on the link handshake
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (link_rx_busy !== v && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 500) begin
      mismatches++;
      conclude;
    end
  endtask
  // One byte from the link, waiting until the handshake has returned
  task automatic rx(input logic [7:0] b);
    wait_busy(1'b0);
    link_engine_model_inst.send(b);
    wait_busy(1'b0);
    repeat (3) @(posedge core_clk);
    #2;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #2;
    nrst = 1'b1;
    chk("flags after reset", raw, 5'h00);
    foreach (ofs[i]) begin
      acc(1'b0, ofs[i], 32'h0);
      chk("threshold reset", rd_val, 32'h0);
      acc(1'b1, ofs[i], 32'hFFFF_FF03);
      acc(1'b0, ofs[i], 32'h0);
      chk("threshold reserved", rd_val, 32'h3);
      acc(1'b1, ofs[i], 32'(DEPTH + 1));
      acc(1'b0, ofs[i], 32'h0);
      chk("threshold clamp", rd_val, 32'(DEPTH));
    end
    acc(1'b1, 8'h10, 32'hFF);
    acc(1'b0, 8'h10, 32'h0);
    chk("unmapped read", rd_val, 32'h0);
    controller_enable = 1'b1;
    acc(1'b1, OFS_TX_THR, 32'h2);
    acc(1'b1, OFS_RX_THR, 32'h1);
    chk("tx low empty", raw[4], 1'b1);
    repeat (3) dcmd(1'b1);
    chk("tx low above", raw[4], 1'b0);
    link_engine_model_inst.pop;
    repeat (8) @(posedge core_clk);
    #2;
    chk("tx low at threshold", raw[4], 1'b1);
    repeat (DEPTH - 2) dcmd(1'b1);
    chk("tx over early", raw[3], 1'b0);
    dcmd(1'b1);
    chk("tx over", raw[3], 1'b1);
    acc(1'b0, OFS_CLR_ALL, 32'h0);
    chk("combined clear value", rd_val, 32'h1);
    chk("tx over cleared", raw[3], 1'b0);
    chk("abort clear pulse", abort_cause_clear, 1'b1);
    rx(8'h5A);
    chk("rx level one", raw[2], 1'b0);
    rx(8'hC3);
    chk("rx level two", raw[2], 1'b1);
    abort_cause_bit9 = 1'b1;
    acc(1'b0, OFS_CLR_ALL, 32'h0);
    chk("rx level kept", raw[2], 1'b1);
    chk("abort clear kept", abort_cause_clear, 1'b0);
    dcmd(1'b0);
    chk("first byte", rx_data, 8'h5A);
    chk("rx level below", raw[2], 1'b0);
    dcmd(1'b0);
    dcmd(1'b0);
    chk("underflow", raw[0], 1'b1);
    chk("data kept", rx_data, 8'hC3);
    acc(1'b0, OFS_CLR_UNDER, 32'h0);
    chk("underflow clear value", rd_val, 32'h1);
    chk("underflow cleared", raw[0], 1'b0);
    for (int i = 0; i <= DEPTH; i++) begin
      rx(8'h10 + 8'(i));
    end
    chk("rx overflow", raw[1], 1'b1);
    acc(1'b0, OFS_CLR_ALL, 32'h0);
    chk("rx overflow cleared", raw[1], 1'b0);
    abort_cause_bit9 = 1'b0;
    receive_full_hold_control = 1'b1;
    link_engine_model_inst.send(8'hEE);
    repeat (20) @(posedge core_clk);
    #2;
    chk("link stalled", link_rx_busy, 1'b1);
    chk("no overflow held", raw[1], 1'b0);
    dcmd(1'b0);
    chk("oldest byte", rx_data, 8'h10);
    wait_busy(1'b0);
    repeat (DEPTH) dcmd(1'b0);
    chk("dropped byte skipped", rx_data, 8'hEE);
    rx(8'h01);
    rx(8'h02);
    dcmd(1'b1);
    controller_enable = 1'b0;
    @(posedge core_clk);
    #2;
    chk("rx level off", raw[2], 1'b0);
    repeat (10) @(posedge core_clk);
    #2;
    chk("tx over held", raw[3], 1'b1);
    link_engine_model_inst.engine_idle = 1'b1;
    repeat (8) @(posedge core_clk);
    #2;
    chk("internal enable off", internal_enable_state, 1'b0);
    chk("flags off when idle", raw, 5'h00);
    conclude;
  end
endmodule
